// [tafc_regs.svh]
// Register offsets, field positions, reset values and timing counts.
// Assumes inclusion by the acquisition-timing design file and the bench.
`ifndef TAFC_REGS_SVH
`define TAFC_REGS_SVH

`define TAFC_CTRL_OFF 12'h000
`define TAFC_HOP_OFF 12'h004
`define TAFC_SAMP_OFF 12'h008
`define TAFC_STAT_OFF 12'h00c
`define TAFC_RES_OFF 12'h010

`define TAFC_CTRL_EN_BIT 0
`define TAFC_CTRL_MODE_LSB 1
`define TAFC_CTRL_PRSC_LSB 3
`define TAFC_CTRL_OS_LSB 5
`define TAFC_CTRL_START_BIT 8
`define TAFC_CTRL_RST 32'h0000_0000
`define TAFC_HOP_RST 32'h0000_0000

`define TAFC_CYCLES_PER_ACQ 5'h0f
`define TAFC_THRESH 16'h0040

`endif

// [tafc_pkg.sv]
// Types shared by the acquisition-timing control block.
// Numeric constants stay in tafc_regs.svh; this package uses none of them.
package tafc_pkg;
	typedef enum logic [1:0] {
		FREQ_NONE,
		FREQ_SPREAD,
		FREQ_HOP,
		FREQ_RSVD
	} tafc_mode_t;

	typedef enum logic [1:0] {
		clk_div_by_one,
		clk_div_by_two,
		clk_div_by_four,
		clk_div_by_eight
	} tafc_prsc_t;

	typedef enum {
		ST_IDLE,
		ST_ACQ,
		ST_GAP
	} tafc_state_t;
endpackage : tafc_pkg

// [tafc_median3.sv]
// Three-input median selector for the hop-mode result path.
// Assumes its inputs are settled values on the same clock.
module tafc_median3 (
	// Samples
	input wire logic [15:0] sampA,
	input wire logic [15:0] sampB,
	input wire logic [15:0] sampC,
	// Median
	output logic [15:0] median
);
	logic abGt;
	logic acGt;
	logic bcGt;

	always_comb begin
		abGt = sampA > sampB;
		acGt = sampA > sampC;
		bcGt = sampB > sampC;
		// Outlier dropped: middle value kept
		if (abGt ~^ acGt) begin
			median = (abGt ^ bcGt) ? sampC : sampB;
		end else begin
			median = sampA;
		end
	end
endmodule : tafc_median3

// [tafc_acq_ctrl.sv]
// Acquisition timing and frequency-mode control with APB registers.
// Assumes one clock mclk, synchronous active-high rst, APB master.
// How it works
// - No-variation mode samples at fixed rate, no extra gap cycles.
// - Spread mode varies gap between samples in a saw-tooth sequence.
// - Spread period spans base period to twice base period.
// - Hop mode uses three delay settings plus median filtering.
// - Hop slot steps 0,1,2 per measurement cycle, then wraps.
// - Median rejects the outlying per-frequency measurement.
// - Acquisition lasts 15 controller cycles; hop delay cycles follow it in the gap.
// - Hop setting n inserts n idle controller cycles.
// - Controller tick is mclk divided by 1, 2, 4 or 8.
// - Oversampling extra samples only when reading changed significantly.
`include "tafc_regs.svh"
module tafc_acq_ctrl (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Acquisition strobes and sample input
	output logic acqActive,
	output logic acqDone,
	output logic cycleDone,
	output logic [1:0] hopSlot,
	input wire logic [15:0] sampleIn
);
	logic [31:0] ctrl, next_ctrl;
	logic [11:0] hopSet, next_hopSet;
	logic [15:0] lastSample, next_lastSample;
	logic [15:0] hist [3];
	logic [15:0] next_hist [3];
	logic [15:0] result, next_result;
	logic [15:0] medianVal;
	logic [15:0] medIn [3];
	logic bigChange, next_bigChange;
	logic [31:0] next_prdata;
	logic [2:0] prscCnt, next_prscCnt;
	logic [4:0] cycCnt, next_cycCnt;
	logic [4:0] gapCnt, next_gapCnt;
	logic [3:0] spreadPos, next_spreadPos;
	logic [1:0] next_hopSlot;
	logic [3:0] osLeft, next_osLeft;
	logic next_acqDone, next_cycleDone;
	tafc_pkg::tafc_state_t state, next_state;
	tafc_pkg::tafc_mode_t mode;
	tafc_pkg::tafc_prsc_t prsc;
	logic tick, wrEn, rdEn, startReq;
	logic [15:0] diff;
	logic [2:0] divMask;

	assign mode = tafc_pkg::tafc_mode_t'(ctrl[`TAFC_CTRL_MODE_LSB +: 2]);
	assign prsc = tafc_pkg::tafc_prsc_t'(ctrl[`TAFC_CTRL_PRSC_LSB +: 2]);
	assign pready = 1'b1;
	assign wrEn = psel & penable & pwrite;
	// Read data loaded in setup so it stands at the access edge
	assign rdEn = psel & ~penable & ~pwrite;
	assign startReq = wrEn && paddr == `TAFC_CTRL_OFF
		&& pwdata[`TAFC_CTRL_START_BIT];
	assign acqActive = state == tafc_pkg::ST_ACQ;

	// Newest measurement joins the median in the cycle that stores it
	for (genvar k = 0; k < 3; k++) begin : g_med_in
		assign medIn[k] = hopSlot == 2'(k) ? lastSample : hist[k];
	end

	tafc_median3 u_med (
		.sampA(medIn[0]),
		.sampB(medIn[1]),
		.sampC(medIn[2]),
		.median(medianVal)
	);

	always_comb begin
		case (prsc)
			tafc_pkg::clk_div_by_one: divMask = 3'h0;
			tafc_pkg::clk_div_by_two: divMask = 3'h1;
			tafc_pkg::clk_div_by_four: divMask = 3'h3;
			default: divMask = 3'h7;
		endcase
		tick = (prscCnt & divMask) == divMask;
		diff = sampleIn > lastSample ? sampleIn - lastSample
			: lastSample - sampleIn;
	end

	// Register file
	always_comb begin
		next_ctrl = ctrl;
		next_hopSet = hopSet;
		next_prdata = prdata;
		pslverr = 1'b0;
		if (psel && penable && paddr != `TAFC_CTRL_OFF
			&& paddr != `TAFC_HOP_OFF && paddr != `TAFC_SAMP_OFF
			&& paddr != `TAFC_STAT_OFF && paddr != `TAFC_RES_OFF) begin
			pslverr = 1'b1;
		end
		if (wrEn && paddr == `TAFC_CTRL_OFF) begin
			next_ctrl = {23'h000000, 1'b0, pwdata[7:0]};
		end
		if (wrEn && paddr == `TAFC_HOP_OFF) begin
			next_hopSet = pwdata[11:0];
		end
		if (rdEn) begin
			case (paddr)
				`TAFC_CTRL_OFF: next_prdata = ctrl;
				`TAFC_HOP_OFF: next_prdata = {20'h00000, hopSet};
				`TAFC_SAMP_OFF: next_prdata = {16'h0000, lastSample};
				`TAFC_STAT_OFF: next_prdata = {26'h0000000, spreadPos,
					hopSlot};
				`TAFC_RES_OFF: next_prdata = {16'h0000, result};
				default: next_prdata = 32'h0000_0000;
			endcase
		end
	end

	// Acquisition sequencer
	always_comb begin
		next_state = state;
		next_prscCnt = prscCnt + 3'h1;
		next_cycCnt = cycCnt;
		next_gapCnt = gapCnt;
		next_spreadPos = spreadPos;
		next_hopSlot = hopSlot;
		next_osLeft = osLeft;
		next_lastSample = lastSample;
		next_hist = hist;
		next_result = result;
		next_acqDone = 1'b0;
		next_cycleDone = 1'b0;
		next_bigChange = bigChange;
		case (state)
			tafc_pkg::ST_IDLE: begin
				if (startReq && pwdata[`TAFC_CTRL_EN_BIT]) begin
					next_state = tafc_pkg::ST_ACQ;
					next_cycCnt = 5'h00;
					next_prscCnt = 3'h0;
					next_osLeft = pwdata[`TAFC_CTRL_OS_LSB +: 3] == 3'h0
						? 4'h0 : 4'hf;
				end
			end
			tafc_pkg::ST_ACQ: begin
				if (tick) begin
					next_cycCnt = cycCnt + 5'h01;
					if (cycCnt == `TAFC_CYCLES_PER_ACQ - 5'h01) begin
						next_acqDone = 1'b1;
						next_lastSample = sampleIn;
						next_bigChange = diff > `TAFC_THRESH;
						next_state = tafc_pkg::ST_GAP;
						case (mode)
							tafc_pkg::FREQ_SPREAD: begin
								next_gapCnt = {1'b0, spreadPos};
								next_spreadPos = spreadPos + 4'h1;
							end
							tafc_pkg::FREQ_HOP: begin
								next_gapCnt = {1'b0, hopSet[hopSlot*4 +: 4]};
							end
							default: next_gapCnt = 5'h00;
						endcase
					end
				end
			end
			tafc_pkg::ST_GAP: begin
				if (gapCnt == 5'h00 || tick) begin
					if (gapCnt != 5'h00) begin
						next_gapCnt = gapCnt - 5'h01;
					end else begin
						next_cycCnt = 5'h00;
						// Extra samples only on significant change
						if (osLeft == 4'hf) begin
							next_osLeft = bigChange
								? {1'b0, ctrl[`TAFC_CTRL_OS_LSB +: 3]} - 4'h1
								: 4'h0;
							next_state = bigChange ? tafc_pkg::ST_ACQ
								: tafc_pkg::ST_IDLE;
						end else if (osLeft != 4'h0) begin
							next_osLeft = osLeft - 4'h1;
							next_state = tafc_pkg::ST_ACQ;
						end else begin
							next_state = tafc_pkg::ST_IDLE;
						end
						if (next_state == tafc_pkg::ST_IDLE) begin
							next_cycleDone = 1'b1;
							if (mode == tafc_pkg::FREQ_HOP) begin
								next_hist[hopSlot] = lastSample;
								next_hopSlot = hopSlot == 2'h2 ? 2'h0
									: hopSlot + 2'h1;
								next_result = medianVal;
							end else begin
								next_result = lastSample;
							end
						end
					end
				end
			end
			default: next_state = tafc_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			ctrl <= `TAFC_CTRL_RST;
			hopSet <= 12'h000;
			prdata <= 32'h0000_0000;
			state <= tafc_pkg::ST_IDLE;
			prscCnt <= 3'h0;
			cycCnt <= 5'h00;
			gapCnt <= 5'h00;
			spreadPos <= 4'h0;
			hopSlot <= 2'h0;
			osLeft <= 4'h0;
			lastSample <= 16'h0000;
			hist <= '{16'h0000, 16'h0000, 16'h0000};
			result <= 16'h0000;
			acqDone <= 1'b0;
			cycleDone <= 1'b0;
			bigChange <= 1'b0;
		end else begin
			ctrl <= next_ctrl;
			hopSet <= next_hopSet;
			prdata <= next_prdata;
			state <= next_state;
			prscCnt <= next_prscCnt;
			cycCnt <= next_cycCnt;
			gapCnt <= next_gapCnt;
			spreadPos <= next_spreadPos;
			hopSlot <= next_hopSlot;
			osLeft <= next_osLeft;
			lastSample <= next_lastSample;
			hist <= next_hist;
			result <= next_result;
			acqDone <= next_acqDone;
			cycleDone <= next_cycleDone;
			bigChange <= next_bigChange;
		end
	end

	a_hop_wrap: assert property (@(posedge mclk) disable iff (rst)
		$past(hopSlot) == 2'h2 && cycleDone && mode == tafc_pkg::FREQ_HOP
		|-> hopSlot == 2'h0)
		else $error("hop slot did not wrap");
	a_slot_range: assert property (@(posedge mclk) disable iff (rst)
		hopSlot != 2'h3)
		else $error("hop slot out of range");
	a_none_nogap: assert property (@(posedge mclk) disable iff (rst)
		acqDone && mode == tafc_pkg::FREQ_NONE |-> gapCnt == 5'h00)
		else $error("gap inserted in fixed mode");
	a_hop_gap: assert property (@(posedge mclk) disable iff (rst)
		acqDone && mode == tafc_pkg::FREQ_HOP
		|-> gapCnt == {1'b0, hopSet[$past(hopSlot)*4 +: 4]})
		else $error("hop gap wrong");
	a_spread_step: assert property (@(posedge mclk) disable iff (rst)
		acqDone && mode == tafc_pkg::FREQ_SPREAD
		|-> spreadPos == $past(spreadPos) + 4'h1)
		else $error("spread did not step");
	a_spread_max: assert property (@(posedge mclk) disable iff (rst)
		gapCnt <= 5'h0f)
		else $error("gap beyond base period");
	a_acq_len: assert property (@(posedge mclk) disable iff (rst)
		$rose(acqActive) && prsc == tafc_pkg::clk_div_by_one
		&& ctrl[7:3] == $past(ctrl[7:3])
		|-> acqActive [*8] ##1 acqActive [*7] ##1 acqDone && !acqActive)
		else $error("acquisition length wrong");
	a_div_tick: assert property (@(posedge mclk) disable iff (rst)
		tick && prsc == tafc_pkg::clk_div_by_eight |-> prscCnt == 3'h7)
		else $error("prescaler tick wrong");
	a_med_result: assert property (@(posedge mclk) disable iff (rst)
		cycleDone && mode == tafc_pkg::FREQ_HOP
		&& $stable(ctrl) |-> result == $past(medianVal))
		else $error("result is not median");
	a_os_gate: assert property (@(posedge mclk) disable iff (rst)
		state == tafc_pkg::ST_GAP && gapCnt == 5'h00 && osLeft == 4'hf
		&& !bigChange |=> state == tafc_pkg::ST_IDLE)
		else $error("oversampled without change");
endmodule : tafc_acq_ctrl

// [tafc_sensor_model.sv]
// Behavioural sensor front end feeding samples to the acquisition block.
// Assumes the block captures sampleIn while an acquisition is ending.
module tafc_sensor_model (
	// Strobes from the block
	input wire logic acqActive,
	input wire logic acqDone,
	// Level commanded by the bench
	input wire logic [15:0] level,
	// Sample to the block
	output logic [15:0] sampleIn
);
	timeunit 1ns;
	timeprecision 100ps;
	// Outside an acquisition and its done strobe the value is stale, so show its inverse
	always_comb begin
		sampleIn = (acqActive | acqDone) ? level : ~level;
	end
endmodule : tafc_sensor_model

// [touch_acquisition_freq_control_bench.sv]
// Self-checking bench for the acquisition-timing control block.
// Assumes the design files and the sensor model are compiled first.
`include "tafc_regs.svh"
module touch_acquisition_freq_control_bench;
	timeunit 1ns;
	timeprecision 100ps;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [15:0] level = 16'h0000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic acqActive;
	logic acqDone;
	logic cycleDone;
	logic [1:0] hopSlot;
	logic [15:0] sampleIn;
	int err_count = 0;
	int checked = 0;

	always #2.5 mclk = ~mclk;

	tafc_acq_ctrl dut_u (.mclk(mclk), .rst(rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.acqActive(acqActive), .acqDone(acqDone), .cycleDone(cycleDone),
		.hopSlot(hopSlot), .sampleIn(sampleIn));
	tafc_sensor_model sens_u (.acqActive(acqActive), .acqDone(acqDone),
		.level(level), .sampleIn(sampleIn));

	task complete_run;
		if (err_count == 0 && checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : complete_run

	task chk(input logic ok, input string msg);
		checked++;
		if (ok !== 1'b1) begin
			err_count++;
			$display("wrong value at %0t: %s", $time, msg);
		end
	endtask : chk

	task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		int n;
		@(posedge mclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		@(posedge mclk);
		for (n = 0; n < 50 && pready !== 1'b1; n++) begin
			@(posedge mclk);
		end
		if (n == 50)
			chk(1'b0, "bus answer never came");
		e = pslverr;
		q = w ? 32'h0000_0000 : prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	function automatic logic [31:0] cw(input logic [1:0] m,
		input logic [1:0] p, input logic [2:0] o);
		return {24'h000000, o, p, m, 1'b1};
	endfunction : cw

	task run_cycle(input logic [31:0] ctrl, output int act, output int nd,
		output int gap);
		logic [31:0] q;
		logic e;
		int t;
		act = 0;
		nd = 0;
		gap = 0;
		apb(1'b1, `TAFC_CTRL_OFF, ctrl | 32'h0000_0100, q, e);
		for (t = 0; t < 3000; t++) begin
			#1;
			if (acqActive === 1'b1 && nd == 0)
				act++;
			gap++;
			if (acqDone === 1'b1) begin
				nd++;
				gap = 0;
			end
			if (cycleDone === 1'b1)
				break;
			@(posedge mclk);
		end
		if (t == 3000)
			chk(1'b0, "measurement cycle never ended");
	endtask : run_cycle

	task t_regs;
		logic [31:0] q;
		logic e;
		apb(1'b0, `TAFC_CTRL_OFF, 32'h0, q, e);
		chk(q === `TAFC_CTRL_RST && e === 1'b0, "control reset value");
		apb(1'b0, `TAFC_HOP_OFF, 32'h0, q, e);
		chk(q === `TAFC_HOP_RST && e === 1'b0, "hop reset value");
		apb(1'b1, 12'h020, 32'hffff_ffff, q, e);
		chk(e === 1'b1, "unmapped write not refused");
		apb(1'b0, 12'h020, 32'h0, q, e);
		chk(e === 1'b1 && q === 32'h0, "unmapped read not refused");
	endtask : t_regs

	task t_prescale;
		int a, n, g, i;
		for (i = 0; i < 4; i++) begin
			run_cycle(cw(tafc_pkg::FREQ_NONE, i[1:0], 3'h0), a, n, g);
			chk(a == 15 * (1 << i), "acquisition length");
			chk(n == 1 && g == 1, "gap in fixed mode");
		end
	endtask : t_prescale

	task t_hop;
		logic [15:0] lv [3] = '{16'h0064, 16'h1388, 16'h0078};
		int gp [3] = '{1, 6, 16};
		logic [31:0] q;
		logic e;
		int a, n, g, i;
		// Settings zero, five and fifteen
		apb(1'b1, `TAFC_HOP_OFF, 32'h0000_0f50, q, e);
		for (i = 0; i < 3; i++) begin
			level <= lv[i];
			@(posedge mclk);
			#1;
			chk(hopSlot === i[1:0], "hop slot order");
			run_cycle(cw(tafc_pkg::FREQ_HOP, 2'h0, 3'h0), a, n, g);
			chk(a == 15 && g == gp[i], "hop delay");
		end
		@(posedge mclk);
		#1;
		chk(hopSlot === 2'h0, "hop slot wrap");
		apb(1'b0, `TAFC_RES_OFF, 32'h0, q, e);
		chk(q === 32'h0000_0078, "median result");
	endtask : t_hop

	task t_spread;
		int a, n, g, i, last;
		logic [31:0] q;
		logic e;
		last = -1;
		for (i = 0; i < 3; i++) begin
			run_cycle(cw(tafc_pkg::FREQ_SPREAD, 2'h0, 3'h0), a, n, g);
			chk(a == 15 && g >= 1 && g <= 16, "spread range");
			chk(g != last, "spread gap stuck");
			last = g;
		end
		apb(1'b0, `TAFC_STAT_OFF, 32'h0, q, e);
		chk(q === 32'h0000_000c && e === 1'b0, "status word");
	endtask : t_spread

	task t_oversample;
		int a, n, g;
		logic [31:0] q;
		logic e;
		level <= 16'h1000;
		run_cycle(cw(tafc_pkg::FREQ_NONE, 2'h0, 3'h2), a, n, g);
		chk(n == 3, "extra samples on change");
		run_cycle(cw(tafc_pkg::FREQ_NONE, 2'h0, 3'h2), a, n, g);
		chk(n == 1, "extra samples when steady");
		apb(1'b0, `TAFC_SAMP_OFF, 32'h0, q, e);
		chk(q === 32'h0000_1000 && e === 1'b0, "last sample");
	endtask : t_oversample

	initial begin
		repeat (10) @(posedge mclk);
		rst <= 1'b0;
		t_regs();
		t_prescale();
		t_hop();
		t_spread();
		t_oversample();
		complete_run();
	end

	initial begin
		#300000;
		err_count++;
		complete_run();
	end
endmodule : touch_acquisition_freq_control_bench
